/* File: design/acst_config_port.sv */
// acst_config_port: three-wire serial configuration port, register file,
// self-test and output test-pattern control of a two-core converter.
// assumes: serial pins are asynchronous to sys_clk and far slower than it
// Notes on behaviour
// RL1: output-disable high three-states both data buses
// RL2: self-test feeds pseudorandom data, accumulates CRC
// RL3: self-test runs exactly 512 cycles, then stops
// RL4: signature match sets pass bit, else clears
// RL5: writing 0x05 starts test with generator reseed
// RL6: enable bit clears itself when test completes
// RL7: without init, generator continues from last value
// RL8: data outputs show pseudorandom data during test
// RL9: test mode replaces converter data with pattern
// RL10: pattern bits 4/5 reset pattern generators
// RL11: test patterns run on sample clock, ignore input
// RL12: frame starts on select fall then clock rise
// RL13: select held low keeps port streaming
// RL14: select high between bytes stalls, then resumes
// RL15: select tied high floats pins, enables straps
// RL16: 16-bit instruction, then data per word-length
// RL17: data in bytes; first bit is read/write
// RL18: readback turns data pin around, master releases
// RL19: bit order MSB first, LSB first configurable
// RL20: strap high at power-on gives full power-down
// RL21: master keeps port idle during sampling
// RL22: program registers shadowed, applied on transfer write
// RL23: channel index selects local register copies
// RL24: instruction: r/w, two length bits, 13-bit address
// RL25: sample on rising clock, drive on falling
`timescale 1ns/1ps
module acst_config_port
  import acst_pkg::*;
#(
  parameter logic [7:0]  CHIP_ID  = 8'h5A, // arbitrary value
  parameter logic [15:0] EXPECTED = 16'h0000
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // serial link
  input  wire logic       sclk,
  input  wire logic       portSelect_n,
  input  wire logic       sdioIn,
  output logic            sdioOut,
  output logic            sdioOe,
  // static controls
  input  wire logic       outputDisable,
  // converter data in, per core
  input  wire logic [7:0] adcDataA,
  input  wire logic [7:0] adcDataB,
  // data buses out
  output logic [7:0]      dataOutA,
  output logic [7:0]      dataOutB,
  output logic            dataOe,
  // status and applied settings
  output logic            fullPowerDown,
  output logic [7:0]      offsetAdjA,
  output logic [7:0]      offsetAdjB,
  output logic [7:0]      fineDelay,
  output logic [7:0]      coarseDelay
);
  logic [1:0] rstPipe;
  logic       rstSync_n;
  logic [2:0] sclkPipe, csPipe, sdiPipe;
  logic       sclkS, csS, sdiS, sclkPrev, csPrev;
  logic       sclkRise, sclkFall, csFall;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rstPipe <= 2'b00;
    else        rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  // two-flop synchronisers; only stage 2 onward is read
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      sclkPipe <= 3'b000;
      csPipe   <= 3'b111;
      sdiPipe  <= 3'b000;
    end else begin
      sclkPipe <= {sclkPipe[1:0], sclk};
      csPipe   <= {csPipe[1:0], portSelect_n};
      sdiPipe  <= {sdiPipe[1:0], sdioIn};
    end
  end
  assign sclkS    = sclkPipe[1];
  assign sclkPrev = sclkPipe[2];
  assign csS      = csPipe[1];
  assign csPrev   = csPipe[2];
  assign sdiS     = sdiPipe[1];
  assign sclkRise = !csS && sclkS && !sclkPrev; // see RL25
  assign sclkFall = !csS && !sclkS && sclkPrev; // see RL25
  assign csFall   = csPrev && !csS;

  // strap capture at release of reset
  // waits until the synchroniser holds the pin, not its own reset value
  logic       strapPd_reg, selectSeenLow_reg;
  logic [1:0] strapWait_reg;
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      strapWait_reg     <= 2'b00;
      strapPd_reg       <= 1'b0;
      selectSeenLow_reg <= 1'b0;
    end else begin
      if (strapWait_reg != 2'b11) strapWait_reg <= strapWait_reg + 2'd1;
      if (strapWait_reg == 2'b10) strapPd_reg <= sdiS; // see RL20
      if (!csS) selectSeenLow_reg <= 1'b1;
    end
  end
  // port never used: strap functions stay in force
  assign fullPowerDown = strapPd_reg && !selectSeenLow_reg; // see RL15 see RL20

  // serial engine
  acst_state_t state_reg, stateNext;
  logic [15:0] shift_reg;
  logic [4:0]  bitCnt_reg;
  logic [12:0] addr_reg;
  logic        isRead_reg;
  logic [1:0]  wlen_reg;
  logic [1:0]  bytesDone_reg;
  logic [7:0]  txByte_reg;
  logic        txLoad_reg;
  logic        lsbFirst;
  logic        instrDone, byteDone, lastByte;
  logic [7:0]  rxByte, readData, rxRaw;
  logic        wrStrobe;

  // the eighth bit is still in the synchroniser at the byte-done edge
  assign rxRaw = {shift_reg[6:0], sdiS};
  always_comb begin
    rxByte = rxRaw;
    if (lsbFirst) begin
      for (int i = 0; i < 8; i++) rxByte[i] = rxRaw[7 - i]; // see RL19
    end
  end

  assign instrDone = sclkRise && state_reg == ST_INSTR
                     && bitCnt_reg == 5'(INSTR_BITS - 1); // see RL16
  assign byteDone  = sclkRise && (state_reg == ST_WRITE || state_reg == ST_READ)
                     && bitCnt_reg == 5'd7; // see RL17
  // word-length 11 streams; no byte ends the frame, and select high only stalls it
  assign lastByte  = wlen_reg != 2'b11 && bytesDone_reg == wlen_reg; // see RL24
  assign wrStrobe  = byteDone && state_reg == ST_WRITE;

  always_comb begin
    stateNext = state_reg;
    case (state_reg)
      ST_IDLE:  if (csFall || (!csS && sclkRise)) stateNext = ST_INSTR; // see RL12
      ST_INSTR: if (instrDone) stateNext = shift_reg[14] ? ST_READ : ST_WRITE;
      ST_WRITE: if (byteDone && lastByte) stateNext = ST_IDLE;
      ST_READ:  if (byteDone && lastByte) stateNext = ST_IDLE;
      default:  stateNext = ST_IDLE;
    endcase
  end

  // select high between bytes only stalls; frame resumes when low again
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= 16'h0000;
      bitCnt_reg    <= 5'd0;
      addr_reg      <= 13'h0000;
      isRead_reg    <= 1'b0;
      wlen_reg      <= 2'b00;
      bytesDone_reg <= 2'b00;
    end else begin
      state_reg <= stateNext; // see RL13 see RL14
      if (sclkRise) begin
        shift_reg  <= {shift_reg[14:0], sdiS};
        bitCnt_reg <= (instrDone || byteDone) ? 5'd0 : bitCnt_reg + 5'd1;
      end
      if (instrDone) begin
        isRead_reg    <= shift_reg[14]; // see RL24
        wlen_reg      <= shift_reg[13:12];
        addr_reg      <= {shift_reg[11:0], sdiS};
        bytesDone_reg <= 2'b00;
      end
      if (byteDone) begin
        // addresses walk downward in MSB-first, upward in LSB-first
        addr_reg      <= lsbFirst ? addr_reg + 13'd1 : addr_reg - 13'd1;
        bytesDone_reg <= bytesDone_reg + 2'd1;
      end
    end
  end

  // readback shifter, loaded after the rise that ends the instruction or a byte, shifted on falling sclk
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txByte_reg <= 8'h00;
      txLoad_reg <= 1'b0;
      sdioOut    <= 1'b0;
      sdioOe     <= 1'b0;
    end else begin
      // load a cycle late, once the address register has moved on
      txLoad_reg <= instrDone || byteDone;
      if (txLoad_reg) txByte_reg <= readData;
      if (state_reg != ST_READ || csS) begin
        sdioOe <= 1'b0; // see RL15
      end else if (sclkFall) begin
        sdioOe     <= 1'b1; // see RL18
        sdioOut    <= lsbFirst ? txByte_reg[0] : txByte_reg[7]; // see RL25
        txByte_reg <= lsbFirst ? {1'b0, txByte_reg[7:1]}
                               : {txByte_reg[6:0], 1'b0};
      end
    end
  end

  // register file
  logic [7:0] portCfg_reg, chanIdx_reg, xfer_reg;
  logic [7:0] shPat_reg, shOffA_reg, shOffB_reg, shFine_reg, shCoarse_reg;
  logic [7:0] pattern_reg, selfTest_reg;
  logic       stRunning, stDone, stPass;
  logic [15:0] pnData;
  logic       stStart;
  logic [12:0] wrAddr;

  assign lsbFirst = portCfg_reg[BIT_LSB_FIRST] | portCfg_reg[BIT_LSB_FIRST2];
  assign wrAddr   = addr_reg;
  assign stStart  = wrStrobe && wrAddr == ADDR_SELF_TEST && rxByte[BIT_ST_GO];

  always_comb begin
    case (addr_reg)
      ADDR_PORT_CFG:   readData = portCfg_reg;
      ADDR_CHIP_ID:    readData = CHIP_ID;
      ADDR_CHAN_INDEX: readData = chanIdx_reg;
      ADDR_TEST_PAT:   readData = shPat_reg;
      ADDR_SELF_TEST:  readData = {selfTest_reg[7:1],
                                   stRunning | stPass};
      // both channels selected reads channel 1
      ADDR_OFFS_ADJ:   readData = chanIdx_reg[BIT_CHAN1] ? shOffA_reg
                                                         : shOffB_reg; // see RL23
      ADDR_FINE_DLY:   readData = shFine_reg;
      ADDR_COARSE_DLY: readData = shCoarse_reg;
      ADDR_TRANSFER:   readData = xfer_reg;
      default:         readData = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      portCfg_reg  <= PORT_CFG_RST;
      chanIdx_reg  <= CHAN_INDEX_RST;
      xfer_reg     <= ZERO_RST;
      shPat_reg    <= ZERO_RST;
      shOffA_reg   <= ZERO_RST;
      shOffB_reg   <= ZERO_RST;
      shFine_reg   <= ZERO_RST;
      shCoarse_reg <= ZERO_RST;
      selfTest_reg <= ZERO_RST;
    end else begin
      xfer_reg <= ZERO_RST; // see RL22
      // a new start written in the same cycle wins over the clear
      if (stDone) selfTest_reg[BIT_ST_GO] <= 1'b0; // see RL6
      if (wrStrobe) begin
        case (wrAddr)
          ADDR_PORT_CFG:   portCfg_reg <= rxByte;
          ADDR_CHAN_INDEX: chanIdx_reg <= rxByte;
          ADDR_TEST_PAT:   shPat_reg   <= rxByte;
          ADDR_SELF_TEST:  selfTest_reg <= rxByte;
          ADDR_OFFS_ADJ: begin
            if (chanIdx_reg[BIT_CHAN1]) shOffA_reg <= rxByte; // see RL23
            if (chanIdx_reg[BIT_CHAN2]) shOffB_reg <= rxByte; // see RL23
          end
          ADDR_FINE_DLY:   shFine_reg   <= rxByte;
          ADDR_COARSE_DLY: shCoarse_reg <= rxByte;
          ADDR_TRANSFER:   xfer_reg     <= rxByte;
          default:         xfer_reg     <= ZERO_RST;
        endcase
      end
    end
  end

  // live copies updated together on transfer
  logic xferHit;
  assign xferHit = xfer_reg[BIT_XFER];
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pattern_reg <= ZERO_RST;
      offsetAdjA  <= ZERO_RST;
      offsetAdjB  <= ZERO_RST;
      fineDelay   <= ZERO_RST;
      coarseDelay <= ZERO_RST;
    end else if (xferHit) begin
      pattern_reg <= shPat_reg; // see RL22
      offsetAdjA  <= shOffA_reg;
      offsetAdjB  <= shOffB_reg;
      fineDelay   <= shFine_reg;
      coarseDelay <= shCoarse_reg;
    end
  end

  acst_self_test #(
    .CYCLES   (SELF_TEST_CYCLES),
    .EXPECTED (EXPECTED)
  ) u_selfTest (
    .sys_clk   (sys_clk),
    .rstSync_n (rstSync_n),
    .start     (stStart),
    .reseed    (rxByte[BIT_ST_INIT]),
    .running   (stRunning),
    .done      (stDone),
    .pass      (stPass),
    .pnData    (pnData)
  );

  // pattern generators on sys_clk, standing in for the sample clock
  logic [7:0] patA_reg, patB_reg, patSelA, patSelB;
  logic       patRstA, patRstB;
  assign patRstA = pattern_reg[BIT_PAT_RST_A];
  assign patRstB = pattern_reg[BIT_PAT_RST_B];
  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      patA_reg <= 8'hFF;
      patB_reg <= 8'hFF;
    end else begin
      patA_reg <= patRstA ? 8'hFF
                  : {patA_reg[6:0], patA_reg[7] ^ patA_reg[5]}; // see RL10
      patB_reg <= patRstB ? 8'hFF
                  : {patB_reg[6:0], patB_reg[7] ^ patB_reg[3]}; // see RL10
    end
  end

  // analog data ignored whenever a pattern is selected
  always_comb begin
    case (pattern_reg[3:0])
      4'h0:    begin patSelA = adcDataA; patSelB = adcDataB; end
      4'h1:    begin patSelA = 8'h80;    patSelB = 8'h80;    end
      4'h2:    begin patSelA = 8'hFF;    patSelB = 8'hFF;    end
      4'h3:    begin patSelA = 8'h00;    patSelB = 8'h00;    end
      4'h4:    begin patSelA = 8'hAA;    patSelB = 8'h55;    end
      4'h5:    begin patSelA = patA_reg; patSelB = patA_reg; end
      default: begin patSelA = patB_reg; patSelB = patB_reg; end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dataOutA <= 8'h00;
      dataOutB <= 8'h00;
    end else if (stRunning) begin
      dataOutA <= pnData[7:0];  // see RL8
      dataOutB <= pnData[15:8]; // see RL8
    end else begin
      dataOutA <= patSelA; // see RL9 see RL11
      dataOutB <= patSelB; // see RL9 see RL11
    end
  end
  assign dataOe = !outputDisable && !fullPowerDown; // see RL1
endmodule

/* File: include/acst_pkg.sv */
// acst_pkg: constants and carrier types for the serial configuration port
// assumes: included before every design file of the block
package acst_pkg;
  // register offsets (13-bit address space)
  localparam logic [12:0] ADDR_PORT_CFG   = 13'h0000;
  localparam logic [12:0] ADDR_CHIP_ID    = 13'h0001;
  localparam logic [12:0] ADDR_CHAN_INDEX = 13'h0005;
  localparam logic [12:0] ADDR_TEST_PAT   = 13'h000D;
  localparam logic [12:0] ADDR_SELF_TEST  = 13'h000E;
  localparam logic [12:0] ADDR_OFFS_ADJ   = 13'h0010;
  localparam logic [12:0] ADDR_FINE_DLY   = 13'h0037;
  localparam logic [12:0] ADDR_COARSE_DLY = 13'h0038;
  localparam logic [12:0] ADDR_TRANSFER   = 13'h00FF;
  // reset values
  localparam logic [7:0]  PORT_CFG_RST    = 8'h18;
  localparam logic [7:0]  CHAN_INDEX_RST  = 8'h03;
  localparam logic [7:0]  ZERO_RST        = 8'h00;
  // field positions
  localparam int BIT_LSB_FIRST  = 6;
  localparam int BIT_LSB_FIRST2 = 1;
  localparam int BIT_ST_GO      = 0;
  localparam int BIT_ST_INIT    = 2;
  localparam int BIT_PAT_RST_A  = 4;
  localparam int BIT_PAT_RST_B  = 5;
  localparam int BIT_XFER       = 0;
  localparam int BIT_CHAN1      = 0;
  localparam int BIT_CHAN2      = 1;
  localparam int INSTR_BITS     = 16;
  // self-test
  localparam int           SELF_TEST_CYCLES = 512;
  localparam logic [15:0]  LFSR_SEED        = 16'hACE1;
  localparam logic [15:0]  CRC_SEED         = 16'hFFFF;
  localparam logic [15:0]  CRC_POLY         = 16'h1021;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_INSTR = 4'b0010,
    ST_WRITE = 4'b0100,
    ST_READ  = 4'b1000
  } acst_state_t;

  typedef struct packed {
    logic        write;
    logic [7:0]  data;
    logic [12:0] addr;
  } acst_access_t;
endpackage

/* File: design/acst_self_test.sv */
// acst_self_test: pseudorandom source, CRC signature and pass flag
// assumes: start is a one-cycle pulse on sys_clk, rstSync_n synchronous copy
`timescale 1ns/1ps
module acst_self_test
  import acst_pkg::*;
#(
  parameter int          CYCLES   = SELF_TEST_CYCLES,
  parameter logic [15:0] EXPECTED = 16'h0000
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstSync_n,
  // control
  input  wire logic       start,
  input  wire logic       reseed,
  // status and data
  output logic            running,
  output logic            done,
  output logic            pass,
  output logic [15:0]     pnData
);
  initial begin
    if (CYCLES < 1 || CYCLES > 65535) $error("bad self-test length");
  end

  logic [15:0] lfsr_reg;
  logic [15:0] lfsrNext;
  logic [15:0] crc_reg;
  logic [15:0] crcNext;
  logic [15:0] count_reg;
  logic        lastCycle;

  function automatic logic [15:0] crcStep(input logic [15:0] c,
                                          input logic [15:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign lfsrNext  = {lfsr_reg[14:0],
                      lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  assign crcNext   = crcStep(crc_reg, lfsr_reg);
  assign lastCycle = running && (count_reg == 16'(CYCLES - 1)); // see RL3
  assign pnData    = lfsr_reg;

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lfsr_reg  <= LFSR_SEED;
      crc_reg   <= CRC_SEED;
      count_reg <= 16'h0000;
      running   <= 1'b0;
      done      <= 1'b0;
      pass      <= 1'b0;
    end else begin
      // a restart in the last cycle must not report the old run as done
      done <= lastCycle && !start;
      if (start) begin
        running   <= 1'b1;
        count_reg <= 16'h0000;
        crc_reg   <= CRC_SEED;
        // without reseed the source carries on from its last value
        if (reseed) lfsr_reg <= LFSR_SEED; // see RL5 see RL7
      end else if (running) begin
        lfsr_reg  <= lfsrNext; // see RL2
        crc_reg   <= crcNext;  // see RL2
        count_reg <= count_reg + 16'h0001;
        if (lastCycle) begin
          running <= 1'b0; // see RL3
          pass    <= (crcNext == EXPECTED); // see RL4
        end
      end
    end
  end
endmodule

/* File: testbench/acst_config_port_chk.sv */
// acst_config_port_chk: port-level checks of the configuration port
// assumes: bound to every acst_config_port, one sys_clk domain
`timescale 1ns/1ps
module acst_config_port_chk (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic portSelect_n,
  input wire logic sdioOut,
  input wire logic sdioOe,
  // output control
  input wire logic outputDisable,
  input wire logic dataOe,
  input wire logic fullPowerDown
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  // select needs two sync flops plus one register to be seen
  sequence selHigh;
    portSelect_n [*6];
  endsequence
  sequence selLow;
    !portSelect_n [*6];
  endsequence
  sequence sclkHigh;
    sclk [*4];
  endsequence
  chk_bus_disable: assert property (outputDisable |-> !dataOe)
    else $error("data buses driven while disabled");
  chk_bus_enabled: assert property ((!outputDisable && !fullPowerDown) |-> dataOe)
    else $error("data buses floating while enabled");
  chk_powerdown_float: assert property (fullPowerDown |-> !dataOe)
    else $error("data buses driven in power-down");
  chk_select_float: assert property (selHigh |-> !sdioOe)
    else $error("data pin driven while not selected");
  chk_readback_hold: assert property (sclkHigh |-> $stable(sdioOut))
    else $error("readback bit moved while clock high");
  chk_oe_in_frame: assert property ($rose(sdioOe) |-> !portSelect_n)
    else $error("data pin turned round outside a frame");
  chk_oe_after_fall: assert property ($rose(sdioOe) |-> !$past(sclk, 2))
    else $error("data pin turned round not after a falling edge");
  chk_strap_cleared: assert property (selLow |-> !fullPowerDown)
    else $error("power-down kept while port in use");
endmodule

bind acst_config_port acst_config_port_chk i_acst_config_port_chk (
  .sys_clk,
  .rst_n,
  .sclk,
  .portSelect_n,
  .sdioOut,
  .sdioOe,
  .outputDisable,
  .dataOe,
  .fullPowerDown
);

/* File: testbench/acst_spi_master.sv */
// acst_spi_master: serial master model for the three-wire port
// assumes: tasks are called just after a rising edge of sys_clk
`timescale 1ns/1ps
module acst_spi_master (
  // clock
  input wire logic sys_clk,
  // serial link
  output logic     sclk,
  output logic     portSelect_n,
  output logic     sdioIn,
  input wire logic sdioOut,
  input wire logic sdioOe
);
  logic mDrive;
  logic mBit;
  logic lineLast = 1'b0;
  logic sdioLine;
  // no pull on the pin: an undriven line toggles instead of holding
  assign sdioLine = sdioOe ? sdioOut : (mDrive ? mBit : ~lineLast);
  assign sdioIn = sdioLine;
  always @(posedge sys_clk) lineLast <= sdioLine;
  initial begin
    sclk = 1'b0;
    portSelect_n = 1'b1;
    mDrive = 1'b1;
    mBit = 1'b0;
  end
  task strap(input logic b);
    mBit <= b;
    mDrive <= 1'b1;
  endtask
  // 4 cycles low, 4 high: 320 ns per bit
  task bitx(input logic b, input logic drv, output logic r);
    mBit <= b;
    mDrive <= drv;
    repeat (4) @(posedge sys_clk);
    sclk <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // sample between edges, where the device's outputs have settled
    @(negedge sys_clk);
    r = sdioLine;
    @(posedge sys_clk);
    sclk <= 1'b0;
  endtask
  task xfer(input logic rd, input logic [12:0] addr, input int nb,
            input logic [23:0] wd, input logic lsb, input logic stall,
            output logic [23:0] rdat);
    logic [15:0] ins;
    logic r;
    int i;
    int k;
    ins = {rd, 2'(nb - 1), addr};
    rdat = '0;
    portSelect_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    for (i = 15; i >= 0; i--) bitx(ins[i], 1'b1, r);
    for (k = 0; k < nb; k++) begin
      for (i = 0; i < 8; i++) begin
        bitx(wd[23 - 8 * k - (lsb ? 7 - i : i)], !rd, r);
        rdat[23 - 8 * k - (lsb ? 7 - i : i)] = r;
      end
      if (stall && k < nb - 1) begin
        repeat (4) @(posedge sys_clk);
        portSelect_n <= 1'b1;
        repeat (12) @(posedge sys_clk);
        portSelect_n <= 1'b0;
      end
    end
    repeat (4) @(posedge sys_clk);
    portSelect_n <= 1'b1;
    mDrive <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

/* File: testbench/tb_acst_config_port.sv */
// tb_acst_config_port: register-level tests of the configuration port
// assumes: acst_spi_master plays the serial master
`timescale 1ns/1ps
module tb_acst_config_port;
  import acst_pkg::*;
  localparam logic [7:0] ID = 8'hA7; // arbitrary value
  localparam int LIMIT = 20000;
  logic sys_clk, rst_n, sclk, portSelect_n, sdioIn, sdioOut, sdioOe;
  logic outputDisable, dataOe, fullPowerDown;
  logic [7:0] adcDataA, adcDataB, dataOutA, dataOutB, prevA;
  logic [7:0] offsetAdjA, offsetAdjB, fineDelay, coarseDelay;
  logic [23:0] v;
  logic lsbMode;
  int n_mismatch, comparisons, cycles, nChange, j;
  acst_config_port #(.CHIP_ID(ID)) i_acst_config_port (.sys_clk, .rst_n,
    .sclk, .portSelect_n, .sdioIn, .sdioOut, .sdioOe, .outputDisable,
    .adcDataA, .adcDataB, .dataOutA, .dataOutB, .dataOe, .fullPowerDown,
    .offsetAdjA, .offsetAdjB, .fineDelay, .coarseDelay);
  acst_spi_master i_acst_spi_master (.sys_clk, .sclk, .portSelect_n,
    .sdioIn, .sdioOut, .sdioOe);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_mismatch++;
      print_verdict();
    end
  end
  task chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task wr(input logic [12:0] a, input int nb, input logic [23:0] d,
          input logic st);
    i_acst_spi_master.xfer(1'b0, a, nb, d << (8 * (3 - nb)), lsbMode, st, v);
  endtask
  task rdv(input logic [12:0] a, input int nb);
    i_acst_spi_master.xfer(1'b1, a, nb, 24'h00_0000, lsbMode, 1'b0, v);
    v = v >> (8 * (3 - nb));
  endtask
  task chkRd(input string what, input logic [12:0] a, input int nb,
             input logic [23:0] exp);
    rdv(a, nb);
    chk(what, exp, v);
  endtask
  // shadowed writes land a couple of cycles after the last rise
  task apply;
    wr(ADDR_TRANSFER, 1, 24'h00_0001, 1'b0);
    repeat (4) @(posedge sys_clk);
  endtask
  task watchA(input int n);
    nChange = 0;
    prevA = dataOutA;
    repeat (n) begin
      @(negedge sys_clk);
      if (dataOutA !== prevA) nChange++;
      prevA = dataOutA;
    end
    @(posedge sys_clk);
  endtask
  initial begin
    rst_n = 1'b0;
    outputDisable = 1'b0;
    adcDataA = 8'h3C;
    adcDataB = 8'hC3;
    lsbMode = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (12) @(posedge sys_clk);
    chkRd("port cfg", ADDR_PORT_CFG, 1, 24'h00_0018);
    chkRd("chip id", ADDR_CHIP_ID, 1, {16'h0, ID});
    chkRd("chan index", ADDR_CHAN_INDEX, 1, 24'h00_0003);
    chkRd("unmapped", 13'h0013, 1, 24'h00_0000);
    chk("power down", 24'h00_0000, {23'h0, fullPowerDown});
    $display("test reset values done");
    wr(ADDR_OFFS_ADJ, 1, 24'h00_003C, 1'b0);
    chk("offset a held", 24'h00_0000, {16'h0, offsetAdjA});
    apply();
    chk("offset a", 24'h00_003C, {16'h0, offsetAdjA});
    chk("offset b", 24'h00_003C, {16'h0, offsetAdjB});
    chkRd("transfer clear", ADDR_TRANSFER, 1, 24'h00_0000);
    wr(ADDR_CHAN_INDEX, 1, 24'h00_0002, 1'b0);
    wr(ADDR_OFFS_ADJ, 1, 24'h00_0055, 1'b0);
    apply();
    chk("offset b only", 24'h00_0055, {16'h0, offsetAdjB});
    chk("offset a kept", 24'h00_003C, {16'h0, offsetAdjA});
    wr(ADDR_CHAN_INDEX, 1, 24'h00_0003, 1'b0);
    chkRd("both read ch1", ADDR_OFFS_ADJ, 1, 24'h00_003C);
    wr(ADDR_COARSE_DLY, 2, 24'h00_1122, 1'b1);
    apply();
    chk("coarse", 24'h00_0011, {16'h0, coarseDelay});
    chk("fine", 24'h00_0022, {16'h0, fineDelay});
    chkRd("three bytes", ADDR_COARSE_DLY, 3, 24'h11_2200);
    $display("test shadow and channels done");
    wr(ADDR_PORT_CFG, 1, 24'h00_0042, 1'b0);
    lsbMode = 1'b1;
    chkRd("lsb chip id", ADDR_CHIP_ID, 1, {16'h0, ID});
    chkRd("lsb delays", ADDR_FINE_DLY, 2, 24'h00_2211);
    wr(ADDR_PORT_CFG, 1, 24'h00_0018, 1'b0);
    lsbMode = 1'b0;
    chkRd("msb again", ADDR_PORT_CFG, 1, 24'h00_0018);
    $display("test bit order done");
    for (j = 0; j < 2; j++) begin
      wr(ADDR_SELF_TEST, 1, (j == 0) ? 24'h00_0005 : 24'h00_0001, 1'b0);
      watchA(40);
      chk("pn on bus", 24'h00_0001, {23'h0, nChange > 0});
      rdv(ADDR_SELF_TEST, 1);
      chk("test running", 24'h00_0001, {23'h0, v[BIT_ST_GO]});
      repeat (600) @(posedge sys_clk);
      rdv(ADDR_SELF_TEST, 1);
      chk("test finished", 24'h00_0000, {23'h0, v[BIT_ST_GO]});
    end
    @(negedge sys_clk);
    chk("normal data", {16'h0, adcDataA}, {16'h0, dataOutA});
    $display("test self-test done");
    @(posedge sys_clk);
    wr(ADDR_TEST_PAT, 1, 24'h00_0011, 1'b0);
    apply();
    chkRd("pattern reg", ADDR_TEST_PAT, 1, 24'h00_0011);
    adcDataA <= 8'h6D;
    repeat (8) @(negedge sys_clk);
    chk("pattern shown", 24'h00_0001, {23'h0, dataOutA !== 8'h6D});
    @(posedge sys_clk);
    wr(ADDR_TEST_PAT, 1, 24'h00_0015, 1'b0);
    apply();
    watchA(16);
    chk("pattern held", 24'h00_0000, 24'(nChange));
    wr(ADDR_TEST_PAT, 1, 24'h00_0005, 1'b0);
    apply();
    watchA(16);
    chk("pattern runs", 24'h00_0001, {23'h0, nChange > 0});
    wr(ADDR_TEST_PAT, 1, 24'h00_0000, 1'b0);
    apply();
    @(negedge sys_clk);
    chk("data back", 24'h00_006D, {16'h0, dataOutA});
    @(posedge sys_clk);
    outputDisable <= 1'b1;
    @(negedge sys_clk);
    chk("bus disabled", 24'h00_0000, {23'h0, dataOe});
    @(posedge sys_clk);
    outputDisable <= 1'b0;
    $display("test outputs done");
    i_acst_spi_master.strap(1'b1);
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (12) @(negedge sys_clk);
    chk("strap down", 24'h00_0001, {23'h0, fullPowerDown});
    chk("strap float", 24'h00_0000, {23'h0, dataOe});
    @(posedge sys_clk);
    chkRd("port alive", ADDR_CHIP_ID, 1, {16'h0, ID});
    chk("strap left", 24'h00_0000, {23'h0, fullPowerDown});
    $display("test strap done");
    print_verdict();
  end
endmodule
